// ---- hw/special_function_register_map.sv ----
// Operation
// - status bank bits pick one of four banks for direct addressing.
// - indirect data location acts on the address held in the pointer.
// - writing counter low byte loads counter bits 12:8 from high latch.
// - core registers answer at the same offset in every bank.
// - unimplemented locations and bits read as zero.
// - port writes go to the output latch; port reads return pin levels.
// - reset sets every implemented direction bit, making all pins inputs.
`timescale 1ns/10ps

module special_function_register_map (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [6:0]  file_addr,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    input  wire logic        pc_step,
    output logic      [12:0] pc_out,
    output logic      [7:0]  interrupt_control,
    input  wire logic [5:0]  port_a_in,
    output logic      [5:0]  port_a_out,
    output logic      [5:0]  port_a_oe,
    input  wire logic [7:0]  port_b_in,
    output logic      [7:0]  port_b_out,
    output logic      [7:0]  port_b_oe,
    input  wire logic [7:0]  port_c_in,
    output logic      [7:0]  port_c_out,
    output logic      [7:0]  port_c_oe
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]  status_r;
    logic [7:0]  pointer_r;
    logic [4:0]  pc_high_r;
    logic [12:0] pc_r;
    logic [7:0]  interrupt_control_r;
    logic [5:0]  port_a_latch_r;
    logic [7:0]  port_b_latch_r;
    logic [7:0]  port_c_latch_r;
    logic [5:0]  port_a_dir_r;
    logic [7:0]  port_b_dir_r;
    logic [7:0]  port_c_dir_r;
    logic [7:0]  rd_data_r;
    logic [7:0]  gpr_r [sfr_map_pkg::GPR_DEPTH];
    logic [7:0]  periph_r [sfr_map_pkg::NUM_PERIPH];
    logic [5:0]  pin_a_s1_r;
    logic [5:0]  pin_a_s2_r;
    logic [7:0]  pin_b_s1_r;
    logic [7:0]  pin_b_s2_r;
    logic [7:0]  pin_c_s1_r;
    logic [7:0]  pin_c_s2_r;

    // ------------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------------
    logic        via_pointer;
    logic [8:0]  acc_addr;
    logic [6:0]  off;
    logic        odd_bank;
    logic        fold;
    logic [8:0]  key;
    logic        self_ind;
    logic        we;

    assign via_pointer = (file_addr == sfr_map_pkg::OFS_INDIRECT_DATA_PORT);
    assign acc_addr = via_pointer
        ? {status_r[sfr_map_pkg::STATUS_IRP_BIT], pointer_r}
        : {status_r[sfr_map_pkg::STATUS_BANK_HI:
                    sfr_map_pkg::STATUS_BANK_LO], file_addr};
    assign off      = acc_addr[6:0];
    assign odd_bank = acc_addr[7];
    // timer0, option and port b pairs repeat two banks up
    assign fold = (off == sfr_map_pkg::OFS_TIMER0_COUNT)
               || (off == sfr_map_pkg::OFS_PORT_B);
    assign key  = fold ? {1'b0, acc_addr[7:0]} : acc_addr;
    // the pointer aimed at the indirect location itself reads zero
    assign self_ind = (off == sfr_map_pkg::OFS_INDIRECT_DATA_PORT);
    assign we       = wr_en && !self_ind;

    // ------------------------------------------------------------------
    // core decode, bank ignored; port and direction decode uses the bank
    // ------------------------------------------------------------------
    logic hit_pcl;
    logic hit_status;
    logic hit_pointer;
    logic hit_pch;
    logic hit_interrupt_control;
    logic hit_port_a;
    logic hit_port_b;
    logic hit_port_c;
    logic hit_dir_a;
    logic hit_dir_b;
    logic hit_dir_c;

    assign hit_pcl     = (off == sfr_map_pkg::OFS_PC_LOW_BYTE);
    assign hit_status  = (off == sfr_map_pkg::OFS_CORE_STATUS);
    assign hit_pointer = (off == sfr_map_pkg::OFS_INDIRECT_POINTER);
    assign hit_pch     = (off == sfr_map_pkg::OFS_PC_HIGH_LATCH);
    assign hit_interrupt_control  = (off == sfr_map_pkg::OFS_INTERRUPT_CONTROL);
    assign hit_port_a  = (key == {2'b00, sfr_map_pkg::OFS_PORT_A});
    assign hit_port_b  = (key == {2'b00, sfr_map_pkg::OFS_PORT_B});
    assign hit_port_c  = (key == {2'b00, sfr_map_pkg::OFS_PORT_C});
    assign hit_dir_a   = (key == {2'b01, sfr_map_pkg::OFS_PORT_A});
    assign hit_dir_b   = (key == {2'b01, sfr_map_pkg::OFS_PORT_B});
    assign hit_dir_c   = (key == {2'b01, sfr_map_pkg::OFS_PORT_C});

    // ------------------------------------------------------------------
    // general purpose ram: banks 2 and 3 reach the ram of banks 0 and 1
    // ------------------------------------------------------------------
    logic       gpr_low;
    logic       gpr_shared;
    logic       gpr_high;
    logic       gpr_hit;
    logic [6:0] gpr_idx;

    assign gpr_low    = !odd_bank && (off >= sfr_map_pkg::GPR_LOW_START);
    assign gpr_shared = odd_bank && (off >= sfr_map_pkg::GPR_SHARED_START);
    assign gpr_high   = odd_bank && (off >= sfr_map_pkg::GPR_LOW_START)
                     && (off <= sfr_map_pkg::GPR_HIGH_END);
    assign gpr_hit    = gpr_low || gpr_shared || gpr_high;
    assign gpr_idx    = gpr_high ? off + sfr_map_pkg::GPR_HIGH_ADD
                                 : off - sfr_map_pkg::GPR_LOW_START;

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < sfr_map_pkg::GPR_DEPTH; i++) begin
                gpr_r[i] <= sfr_map_pkg::GPR_RST;
            end
        end else if (we && gpr_hit) begin
            gpr_r[gpr_idx] <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // peripheral registers: plain storage, unimplemented bits masked
    // ------------------------------------------------------------------
    logic [sfr_map_pkg::NUM_PERIPH-1:0] periph_hit;
    logic [7:0] periph_view [sfr_map_pkg::NUM_PERIPH];

    for (genvar g = 0; g < sfr_map_pkg::NUM_PERIPH; g++) begin : g_periph
        assign periph_hit[g]  = (key == sfr_map_pkg::PERIPH_OFS[g]);
        assign periph_view[g] = periph_hit[g] ? periph_r[g] : 8'h00;
        always_ff @(posedge clk) begin
            if (srst) begin
                periph_r[g] <= sfr_map_pkg::PERIPH_RST[g];
            end else if (we && periph_hit[g]) begin
                periph_r[g] <= wr_data & sfr_map_pkg::PERIPH_MASK[g];
            end
        end
    end

    logic [7:0] periph_rd;

    always_comb begin
        periph_rd = 8'h00;
        for (int i = 0; i < sfr_map_pkg::NUM_PERIPH; i++) begin
            periph_rd = periph_rd | periph_view[i];
        end
    end

    // ------------------------------------------------------------------
    // core registers
    // ------------------------------------------------------------------
    logic [7:0] status_nxt;

    // power-down and time-out bits are not writable by software
    assign status_nxt = (wr_data & sfr_map_pkg::STATUS_WR_MASK)
                      | (status_r & ~sfr_map_pkg::STATUS_WR_MASK);

    always_ff @(posedge clk) begin
        if (srst) begin
            status_r  <= sfr_map_pkg::STATUS_RST;
            pointer_r <= sfr_map_pkg::POINTER_RST;
            pc_high_r <= sfr_map_pkg::PC_HIGH_RST;
            interrupt_control_r  <= sfr_map_pkg::INTERRUPT_CONTROL_RST;
        end else begin
            if (we && hit_status) begin
                status_r <= status_nxt;
            end
            if (we && hit_pointer) begin
                pointer_r <= wr_data;
            end
            if (we && hit_pch) begin
                pc_high_r <= wr_data[4:0];
            end
            if (we && hit_interrupt_control) begin
                interrupt_control_r <= wr_data;
            end
        end
    end

    // a write to the low byte wins over a step in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            pc_r <= {sfr_map_pkg::PC_HIGH_RST, sfr_map_pkg::PC_LOW_RST};
        end else if (we && hit_pcl) begin
            pc_r <= {pc_high_r, wr_data};
        end else if (pc_step) begin
            pc_r <= pc_r + 13'h0001;
        end
    end

    // ------------------------------------------------------------------
    // ports: latches, directions and pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            port_a_latch_r <= sfr_map_pkg::LATCH_RST[5:0];
            port_b_latch_r <= sfr_map_pkg::LATCH_RST;
            port_c_latch_r <= sfr_map_pkg::LATCH_RST;
            port_a_dir_r   <= sfr_map_pkg::PORT_A_DIR_RST;
            port_b_dir_r   <= sfr_map_pkg::PORT_B_DIR_RST;
            port_c_dir_r   <= sfr_map_pkg::PORT_C_DIR_RST;
        end else begin
            if (we && hit_port_a) begin
                port_a_latch_r <= wr_data[5:0];
            end
            if (we && hit_port_b) begin
                port_b_latch_r <= wr_data;
            end
            if (we && hit_port_c) begin
                port_c_latch_r <= wr_data;
            end
            if (we && hit_dir_a) begin
                port_a_dir_r <= wr_data[5:0];
            end
            if (we && hit_dir_b) begin
                port_b_dir_r <= wr_data;
            end
            if (we && hit_dir_c) begin
                port_c_dir_r <= wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        pin_a_s1_r <= port_a_in;
        pin_a_s2_r <= pin_a_s1_r;
        pin_b_s1_r <= port_b_in;
        pin_b_s2_r <= pin_b_s1_r;
        pin_c_s1_r <= port_c_in;
        pin_c_s2_r <= pin_c_s1_r;
    end

    // ------------------------------------------------------------------
    // read path: one cycle latency, holds between reads
    // ------------------------------------------------------------------
    logic [7:0] rd_nxt;

    always_comb begin
        rd_nxt = 8'h00;
        if (self_ind) begin
            rd_nxt = 8'h00;
        end else if (hit_pcl) begin
            rd_nxt = pc_r[7:0];
        end else if (hit_status) begin
            rd_nxt = status_r;
        end else if (hit_pointer) begin
            rd_nxt = pointer_r;
        end else if (hit_pch) begin
            rd_nxt = {3'b000, pc_high_r};
        end else if (hit_interrupt_control) begin
            rd_nxt = interrupt_control_r;
        end else if (hit_port_a) begin
            rd_nxt = {2'b00, pin_a_s2_r};
        end else if (hit_port_b) begin
            rd_nxt = pin_b_s2_r;
        end else if (hit_port_c) begin
            rd_nxt = pin_c_s2_r;
        end else if (hit_dir_a) begin
            rd_nxt = {2'b00, port_a_dir_r};
        end else if (hit_dir_b) begin
            rd_nxt = port_b_dir_r;
        end else if (hit_dir_c) begin
            rd_nxt = port_c_dir_r;
        end else if (gpr_hit) begin
            rd_nxt = gpr_r[gpr_idx];
        end else begin
            rd_nxt = periph_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_r <= 8'h00;
        end else if (rd_en) begin
            rd_data_r <= rd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rd_data           = rd_data_r;
    assign pc_out            = pc_r;
    assign interrupt_control = interrupt_control_r;
    assign port_a_out        = port_a_latch_r;
    assign port_b_out        = port_b_latch_r;
    assign port_c_out        = port_c_latch_r;
    // a set direction bit makes the pin an input
    assign port_a_oe         = ~port_a_dir_r;
    assign port_b_oe         = ~port_b_dir_r;
    assign port_c_oe         = ~port_c_dir_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_BANK_SELECT: assert property (@(posedge clk) disable iff (srst)
        (wr_en && file_addr == 7'h05 && status_r[6:5] == 2'b01)
        |=> (port_a_oe == ~$past(wr_data[5:0])))
        else $error("bank 1 write did not reach port a direction");

    AST_INDIRECT: assert property (@(posedge clk) disable iff (srst)
        (wr_en && file_addr == 7'h00 && {status_r[7], pointer_r} == 9'h087)
        |=> (port_c_oe == ~$past(wr_data)))
        else $error("indirect write missed the pointed location");

    AST_PC_LOAD: assert property (@(posedge clk) disable iff (srst)
        (wr_en && hit_pcl && !self_ind)
        |=> (pc_out == {$past(pc_high_r), $past(wr_data)}))
        else $error("counter not loaded from high latch");

    AST_CORE_MIRROR: assert property (@(posedge clk) disable iff (srst)
        (rd_en && file_addr == 7'h03 && status_r[6:5] == 2'b11)
        |=> (rd_data == $past(status_r)))
        else $error("status not visible from bank 3");

    AST_UNIMPL_ZERO: assert property (@(posedge clk) disable iff (srst)
        (rd_en && file_addr == 7'h08) |=> (rd_data == 8'h00))
        else $error("unimplemented location read non-zero");

    AST_PIN_READ: assert property (@(posedge clk) disable iff (srst)
        (rd_en && file_addr == 7'h06 && status_r[5] == 1'b0)
        |=> (rd_data == $past(pin_b_s2_r)))
        else $error("port b read did not return pins");

    AST_LATCH_WRITE: assert property (@(posedge clk) disable iff (srst)
        (wr_en && file_addr == 7'h06 && status_r[6:5] == 2'b10)
        |=> (port_b_out == $past(wr_data)))
        else $error("port b write did not reach the latch");

    AST_DIR_RESET: assert property (@(posedge clk)
        srst |=> (port_a_oe == 6'h00 && port_b_oe == 8'h00
                  && port_c_oe == 8'h00))
        else $error("pins not inputs after reset");

    AST_LATCH_HIGH_ZERO: assert property (@(posedge clk)
        disable iff (srst)
        (rd_en && file_addr == 7'h0a) |=> (rd_data[7:5] == 3'b000))
        else $error("high latch upper bits read non-zero");

    AST_INTERRUPT_CONTROL_MIRROR: assert property (@(posedge clk) disable iff (srst)
        (wr_en && file_addr == 7'h0b)
        |=> (interrupt_control == $past(wr_data)))
        else $error("interrupt control write lost in some bank");

    AST_SELF_INDIRECT: assert property (@(posedge clk) disable iff (srst)
        (rd_en && file_addr == 7'h00 && pointer_r[6:0] == 7'h00)
        |=> (rd_data == 8'h00))
        else $error("indirect read of the indirect location non-zero");

    AST_PORT_A_TOP: assert property (@(posedge clk) disable iff (srst)
        (rd_en && file_addr == 7'h05 && status_r[6:5] == 2'b00)
        |=> (rd_data[7:6] == 2'b00))
        else $error("port a unimplemented bits read non-zero");

endmodule : special_function_register_map

// ---- hw/sfr_map_pkg.sv ----
package sfr_map_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_PERIPH = 32;
    localparam int GPR_DEPTH  = 128;

    // ------------------------------------------------------------------
    // offsets in a bank; core ones decoded with the bank bits ignored, ports and timer0 by bank
    // ------------------------------------------------------------------
    localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] OFS_TIMER0_COUNT       = 7'h01;
    localparam logic [6:0] OFS_PC_LOW_BYTE        = 7'h02;
    localparam logic [6:0] OFS_CORE_STATUS        = 7'h03;
    localparam logic [6:0] OFS_INDIRECT_POINTER   = 7'h04;
    localparam logic [6:0] OFS_PORT_A             = 7'h05;
    localparam logic [6:0] OFS_PORT_B             = 7'h06;
    localparam logic [6:0] OFS_PORT_C             = 7'h07;
    localparam logic [6:0] OFS_PC_HIGH_LATCH      = 7'h0a;
    localparam logic [6:0] OFS_INTERRUPT_CONTROL  = 7'h0b;

    // ------------------------------------------------------------------
    // general purpose ram windows
    // ------------------------------------------------------------------
    localparam logic [6:0] GPR_LOW_START    = 7'h20;
    localparam logic [6:0] GPR_HIGH_END     = 7'h3f;
    localparam logic [6:0] GPR_SHARED_START = 7'h70;
    localparam logic [6:0] GPR_HIGH_ADD     = 7'h40;

    // ------------------------------------------------------------------
    // status fields and reset values
    // ------------------------------------------------------------------
    localparam int         STATUS_IRP_BIT   = 7;
    localparam int         STATUS_BANK_HI   = 6;
    localparam int         STATUS_BANK_LO   = 5;
    localparam logic [7:0] STATUS_WR_MASK   = 8'he7;
    localparam logic [7:0] STATUS_RST       = 8'h18;
    localparam logic [4:0] PC_HIGH_RST      = 5'h00;
    localparam logic [7:0] PC_LOW_RST       = 8'h00;
    localparam logic [7:0] INTERRUPT_CONTROL_RST       = 8'h00;
    localparam logic [7:0] POINTER_RST      = 8'h00;
    localparam logic [5:0] PORT_A_DIR_RST   = 6'h3f;
    localparam logic [7:0] PORT_B_DIR_RST   = 8'hff;
    localparam logic [7:0] PORT_C_DIR_RST   = 8'hff;
    localparam logic [7:0] LATCH_RST        = 8'h00;
    localparam logic [7:0] GPR_RST          = 8'h00;

    // ------------------------------------------------------------------
    // peripheral registers: full 9-bit address, implemented bits, reset
    // ------------------------------------------------------------------
    localparam logic [8:0] PERIPH_OFS [NUM_PERIPH] = '{
        9'h001, 9'h00c, 9'h00d, 9'h00e, 9'h00f, 9'h010, 9'h011, 9'h012,
        9'h013, 9'h014, 9'h015, 9'h016, 9'h017, 9'h01e, 9'h01f, 9'h081,
        9'h08c, 9'h08d, 9'h08e, 9'h091, 9'h092, 9'h093, 9'h094, 9'h09e,
        9'h09f, 9'h10c, 9'h10d, 9'h10e, 9'h10f, 9'h18c, 9'h18e, 9'h18f};
    localparam logic [7:0] PERIPH_MASK [NUM_PERIPH] = '{
        8'hff, 8'hff, 8'h59, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h7f,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hfd, 8'hff,
        8'hff, 8'h59, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h8f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h8f, 8'hff, 8'hff};
    localparam logic [7:0] PERIPH_RST [NUM_PERIPH] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

endpackage : sfr_map_pkg

// ---- verification/special_function_register_map_tb_top.sv ----
`timescale 1ns/10ps

`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module special_function_register_map_tb_top;

    logic        clk;
    logic        srst;
    logic [6:0]  file_addr;
    logic        rd_en;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic        pc_step;
    logic [12:0] pc_out;
    logic [7:0]  interrupt_control;
    logic [5:0]  port_a_in;
    logic [5:0]  port_a_out;
    logic [5:0]  port_a_oe;
    logic [7:0]  port_b_in;
    logic [7:0]  port_b_out;
    logic [7:0]  port_b_oe;
    logic [7:0]  port_c_in;
    logic [7:0]  port_c_out;
    logic [7:0]  port_c_oe;
    int          n_fail;
    int          check_count;
    int          i;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [7:0]  v [4];
    logic [1:0]  b;
    // unimplemented spots carry mask 0, partly implemented ones their bits
    logic [8:0]  t_addr [13] = '{9'h008, 9'h009, 9'h018, 9'h01d, 9'h08f,
        9'h095, 9'h105, 9'h107, 9'h187, 9'h010, 9'h01f, 9'h09f, 9'h08e};
    logic [7:0]  t_mask [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'hfd, 8'h8f, 8'h03};

    special_function_register_map uut (
        .clk(clk), .srst(srst), .file_addr(file_addr), .rd_en(rd_en),
        .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
        .pc_step(pc_step), .pc_out(pc_out),
        .interrupt_control(interrupt_control),
        .port_a_in(port_a_in), .port_a_out(port_a_out),
        .port_a_oe(port_a_oe), .port_b_in(port_b_in),
        .port_b_out(port_b_out), .port_b_oe(port_b_oe),
        .port_c_in(port_c_in), .port_c_out(port_c_out),
        .port_c_oe(port_c_oe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // access tasks: one strobe cycle, then one idle cycle
    // ------------------------------------------------------------------
    task automatic acc(input logic w, input logic [6:0] a,
                       input logic [7:0] dv);
        wr_en = w;
        rd_en = ~w;
        file_addr = a;
        wr_data = dv;
        @(posedge clk);
        #2;
        wr_en = 1'b0;
        rd_en = 1'b0;
        @(posedge clk);
        #2;
    endtask : acc

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] ev);
        acc(1'b0, a, 8'h00);
        `CHK(rd_data, ev)
    endtask : rd_chk

    // status bits 4:3 are read-only, so writing them zero is harmless
    task automatic sel_bank(input logic [1:0] bk);
        acc(1'b1, 7'h03, {1'b0, bk, 5'h00});
    endtask : sel_bank

    function automatic logic [7:0] mask_0c(input logic [1:0] bk);
        return (bk == 2'd3) ? 8'h8f : 8'hff;
    endfunction : mask_0c

    task automatic results;
        $display("checks=%0d errors=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        n_fail = 0;
        check_count = 0;
        srst = 1'b1;
        file_addr = 7'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wr_data = 8'h00;
        pc_step = 1'b0;
        port_a_in = 6'h00;
        port_b_in = 8'h00;
        port_c_in = 8'h00;
        void'($urandom(32'h42313314));
        repeat (8) @(posedge clk);
        #2;
        srst = 1'b0;
        `CHK(port_a_oe, 6'h00);
        `CHK(port_b_oe, 8'h00);
        `CHK(port_c_oe, 8'h00);
        sel_bank(2'd1);
        rd_chk(7'h05, 8'h3f);
        rd_chk(7'h06, 8'hff);
        rd_chk(7'h07, 8'hff);
        for (i = 0; i < 4; i++) begin
            v[i] = 8'($urandom) & ((i < 2) ? 8'h4f : 8'hff);
            sel_bank(i[1:0]);
            acc(1'b1, 7'h0c, v[i]);
        end
        for (i = 0; i < 4; i++) begin
            sel_bank(i[1:0]);
            rd_chk(7'h0c, v[i] & mask_0c(i[1:0]));
        end
        for (i = 0; i < 4; i++) begin
            d = $urandom;
            b = i[1:0] + 2'd1;
            sel_bank(i[1:0]);
            acc(1'b1, 7'h04, d);
            acc(1'b1, 7'h0b, ~d);
            sel_bank(b);
            rd_chk(7'h03, {1'b0, b, 5'h18});
            rd_chk(7'h04, d);
            rd_chk(7'h0b, ~d);
            `CHK(interrupt_control, ~d);
        end
        sel_bank(2'd0);
        for (i = 0; i < 3; i++) begin
            d = $urandom;
            e = (i == 0) ? 8'hff : 8'($urandom);
            acc(1'b1, 7'h0a, d);
            rd_chk(7'h0a, {3'b000, d[4:0]});
            acc(1'b1, 7'h02, e);
            `CHK(pc_out, {d[4:0], e});
            pc_step = 1'b1;
            @(posedge clk);
            #2;
            pc_step = 1'b0;
            acc(1'b1, 7'h0a, ~d);
            `CHK(pc_out, {d[4:0], e} + 13'd1);
        end
        sel_bank(2'd1);
        acc(1'b1, 7'h06, 8'h0f);
        `CHK(port_b_oe, 8'hf0);
        sel_bank(2'd0);
        for (i = 0; i < 3; i++) begin
            d = $urandom;
            e = $urandom;
            acc(1'b1, 7'h05, d);
            acc(1'b1, 7'h06, ~d);
            port_a_in = e[5:0];
            port_b_in = ~e;
            port_c_in = e ^ d;
            `CHK(port_a_out, d[5:0]);
            `CHK(port_b_out, ~d);
            repeat (3) @(posedge clk);
            #2;
            rd_chk(7'h05, {2'b00, e[5:0]});
            rd_chk(7'h06, ~e);
            rd_chk(7'h07, e ^ d);
        end
        for (i = 0; i < 13; i++) begin
            sel_bank(t_addr[i][8:7]);
            acc(1'b1, t_addr[i][6:0], 8'hff);
            rd_chk(t_addr[i][6:0], t_mask[i]);
        end
        sel_bank(2'd0);
        for (i = 0; i < 3; i++) begin
            d = $urandom;
            e = 8'h25 + 8'(i);
            acc(1'b1, 7'h04, e);
            acc(1'b1, 7'h00, d);
            rd_chk(e[6:0], d);
            acc(1'b1, 7'h30, ~d);
            acc(1'b1, 7'h04, 8'h30);
            rd_chk(7'h00, ~d);
        end
        d = 8'($urandom) & 8'h4f;
        acc(1'b1, 7'h04, 8'h8c);
        acc(1'b1, 7'h00, d);
        sel_bank(2'd1);
        rd_chk(7'h0c, d);
        d = $urandom;
        acc(1'b1, 7'h05, d);
        `CHK(port_a_oe, ~d[5:0]);
        sel_bank(2'd2);
        acc(1'b1, 7'h06, ~d);
        `CHK(port_b_out, ~d);
        sel_bank(2'd0);
        e = $urandom;
        acc(1'b1, 7'h04, 8'h87);
        acc(1'b1, 7'h00, e);
        `CHK(port_c_oe, ~e);
        acc(1'b1, 7'h07, d);
        `CHK(port_c_out, d);
        acc(1'b1, 7'h04, 8'h80);
        acc(1'b1, 7'h00, d);
        rd_chk(7'h00, 8'h00);
        // mid-run reset brings every register but the pin synchronisers back to its power-on value
        srst = 1'b1;
        @(posedge clk);
        #2;
        srst = 1'b0;
        `CHK(port_c_oe, 8'h00);
        `CHK(pc_out, 13'h0000);
        rd_chk(7'h03, 8'h18);
        rd_chk(7'h0a, 8'h00);
        results();
    end

    // hang guard: a run this long counts as a failure
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end

endmodule : special_function_register_map_tb_top
